/* hw/wwd_sync.sv */
// two-flop synchroniser with rising edge pulse output
`timescale 1ns/1ps
module wwd_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // level in, rising edge pulse out
   input  wire logic din,
   output logic      rise
);
   import wwd_pkg::*;

   logic [2:0] sh_q;

   // two stages then one for edge detect
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sh_q <= 3'h0;
      end else begin
         sh_q <= {sh_q[1:0], din};
      end
   end

   assign rise = sh_q[1] & ~sh_q[2];

endmodule : wwd_sync

/* hw/wwd_top.sv */
// windowed watchdog with control and status registers
//
// Function
// - select below 10011 divides by two to value+5
// - reserved selects act as shortest interval
// - select resets to 01011 or config value
// - select read-only unless config is 11111
// - software enable resets 0, used in mode 01
// - clock select picks one of four oscillators
// - clock select resets 000 when config 111
// - clock select read-only unless config 111
// - window select sets closed eighths of period
// - window select resets to config window value
// - window select read-only unless config 111
// - open when counter at least 4*(7-select)
// - prescale count readable in three parts
// - count byte registers read-only, low resets zero
// - status register read-only, resets all zeros
// - read of first control arms; unarmed clear violates
// - any control write clears watchdog counter
// - window violation resets and clears violation flag
// - config mode governs when the timer runs
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module wwd_top (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // configuration settings
   input  wire wwd_pkg::wwd_config_t cfg,
   // device state
   input  wire logic                 asleep,
   input  wire logic                 clear_instruction,
   input  wire logic                 flag_set_sw,
   // oscillator pins
   input  wire wwd_pkg::wwd_osc_t    osc,
   // register port
   input  wire wwd_pkg::wwd_bus_req_t bus,
   output logic [7:0]                rdata,
   // results
   output logic                      watchdog_reset,
   output logic                      wake_request,
   output logic                      window_violation_flag,
   output logic                      active
);
   import wwd_pkg::*;

   // ---------------------------------------------------------------
   // overview
   // ---------------------------------------------------------------
   // period/enable register layout
   //   bits 7:6  unused, read zero
   //   bits 5:1  prescale select
   //   bit 0     software enable
   // clock/window register layout
   //   bit 7     unused, read zero
   //   bits 6:4  clock select
   //   bit 3     unused, read zero
   //   bits 2:0  window select
   // status register layout
   //   bits 7:3  window counter
   //   bit 2     armed flag
   //   bits 1:0  prescale count bits 17:16
   // count registers
   //   low byte  prescale count bits 7:0
   //   high byte prescale count bits 15:8
   //   no snapshot: a read in three parts may tear while counting
   // lock rules
   //   each field writable only while its config setting is all ones
   //   a locked field keeps its config value from the init cycle
   //   the enable bit is never locked, only ignored outside soft mode
   // counter
   //   one count per rising edge of the chosen oscillator
   //   full period is 2^(select+5) counts
   //   window counter is the top five bits of the period
   //   any control write, a good clear, a time-out or a stop clears it
   // clears
   //   an arming read must come before the clear instruction
   //   a clear while unarmed or in a closed window is a violation
   //   a violation pulls the reset output and clears the flag
   //   a clear while stopped is ignored
   // outputs
   //   reset output pulse is a fixed number of cycles
   //   wake request is one cycle, only while asleep
   //   every output comes from a flip-flop
   // hazards
   //   the oscillators are async: two flops before edge detect
   //   count edges arrive three cycles after the pin edge

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [4:0]          prescale_select_q;
   logic                software_enable_bit_q;
   logic [2:0]          clock_select_q;
   logic [2:0]          window_select_q;
   logic                armed_q;
   logic [WWD_CNT_W-1:0] count_q;
   logic [7:0]          rdata_q;
   logic                rst_out_q;
   logic                wake_q;
   logic                wv_flag_q;
   logic                active_q;
   logic [7:0]          pulse_cnt_q;
   logic                init_q;

   // ---------------------------------------------------------------
   // decode and derived signals
   // ---------------------------------------------------------------
   logic       wr_con0;
   logic       wr_con1;
   logic       rd_con0;
   logic       tick;
   logic [3:0] osc_rise;
   logic [4:0] window_counter;
   logic [WWD_PSC_W-1:0] prescale_count;
   logic       window_open;
   logic [4:0] eff_ps;
   logic       timeout;
   logic       run;
   logic       clr_hit;
   logic       violation;
   logic       clr_ok;

   assign wr_con0 = bus.wr && (bus.addr == WWD_ADDR_PERIOD_ENABLE);
   assign wr_con1 = bus.wr && (bus.addr == WWD_ADDR_CLOCK_WINDOW);
   assign rd_con0 = bus.rd && (bus.addr == WWD_ADDR_PERIOD_ENABLE);

   // ---------------------------------------------------------------
   // oscillator synchronisers and source select
   // ---------------------------------------------------------------
   wwd_sync u_sync_lf (
      .clk  (clk),
      .rstn (rstn),
      .din  (osc.low_freq_internal_osc),
      .rise (osc_rise[0])
   );
   wwd_sync u_sync_mf (
      .clk  (clk),
      .rstn (rstn),
      .din  (osc.medium_freq_internal_osc),
      .rise (osc_rise[1])
   );
   wwd_sync u_sync_so (
      .clk  (clk),
      .rstn (rstn),
      .din  (osc.secondary_osc),
      .rise (osc_rise[2])
   );
   wwd_sync u_sync_ex (
      .clk  (clk),
      .rstn (rstn),
      .din  (osc.external_osc),
      .rise (osc_rise[3])
   );

   // reserved clock codes give no count edges
   always_comb begin
      case (clock_select_q)
         3'h0:    tick = osc_rise[0];
         3'h1:    tick = osc_rise[1];
         3'h2:    tick = osc_rise[2];
         3'h3:    tick = osc_rise[3];
         default: tick = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // activity by operating mode
   // ---------------------------------------------------------------
   always_comb begin
      case (cfg.operating_mode)
         WWD_MODE_ON:    run = 1'b1;
         WWD_MODE_AWAKE: run = !asleep;
         WWD_MODE_SOFT:  run = software_enable_bit_q;
         default:        run = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // counter view: total count is 2^(ps+5) ticks, top five bits = window counter
   // ---------------------------------------------------------------
   assign eff_ps = wwd_eff_ps(prescale_select_q);

   always_comb begin
      logic [WWD_CNT_W-1:0] shifted;
      shifted        = count_q << (5'd23 - eff_ps);
      window_counter = shifted[WWD_CNT_W-1 -: 5];
      prescale_count = shifted[WWD_CNT_W-6 -: WWD_PSC_W];
   end

   assign timeout = tick && run &&
                    (count_q == WWD_CNT_W'((64'h1 << (eff_ps + WWD_PS_BASE_SHIFT)) - 64'h1));

   wwd_window_cmp u_win (
      .window_counter (window_counter),
      .window_select  (window_select_q),
      .window_open    (window_open)
   );

   assign clr_hit   = clear_instruction && run;
   assign clr_ok    = clr_hit && armed_q && window_open;
   assign violation = clr_hit && !(armed_q && window_open);

   // ---------------------------------------------------------------
   // configuration capture after reset release
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         init_q <= 1'b1;
      end else begin
         init_q <= 1'b0;
      end
   end

   // period select and software enable
   always_ff @(posedge clk) begin
      if (!rstn) begin
         prescale_select_q     <= WWD_PS_DEFAULT;
         software_enable_bit_q <= 1'b0;
      end else if (init_q) begin
         prescale_select_q <= (cfg.prescale_setting == WWD_PS_UNLOCKED) ?
                              WWD_PS_DEFAULT : cfg.prescale_setting;
      end else if (wr_con0) begin
         if (cfg.prescale_setting == WWD_PS_UNLOCKED) begin
            prescale_select_q <= bus.wdata[WWD_PS_LSB +: 5];
         end
         software_enable_bit_q <= bus.wdata[WWD_SEN_BIT];
      end
   end

   // clock and window select
   always_ff @(posedge clk) begin
      if (!rstn) begin
         clock_select_q  <= WWD_CS_DEFAULT;
         window_select_q <= WWD_WIN_UNLOCKED;
      end else if (init_q) begin
         clock_select_q  <= (cfg.clock_setting == WWD_CS_UNLOCKED) ?
                            WWD_CS_DEFAULT : cfg.clock_setting;
         window_select_q <= cfg.window_setting;
      end else if (wr_con1) begin
         if (cfg.clock_setting == WWD_CS_UNLOCKED) begin
            clock_select_q <= bus.wdata[WWD_CS_LSB +: 3];
         end
         if (cfg.window_setting == WWD_WIN_UNLOCKED) begin
            window_select_q <= bus.wdata[WWD_WIN_LSB +: 3];
         end
      end
   end

   // ---------------------------------------------------------------
   // watchdog counter
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn || init_q) begin
         count_q <= '0;
      end else if (wr_con0 || wr_con1 || !run || clr_ok || timeout || violation) begin
         count_q <= '0;
      end else if (tick) begin
         count_q <= count_q + WWD_CNT_W'(1);
      end
   end

   // arming: read arms, clear attempt disarms; arming read wins
   always_ff @(posedge clk) begin
      if (!rstn) begin
         armed_q <= 1'b0;
      end else if (rd_con0) begin
         armed_q <= 1'b1;
      end else if (clr_hit || !run) begin
         armed_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // reset, wake and violation flag outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rst_out_q   <= 1'b0;
         pulse_cnt_q <= 8'h00;
      end else if (violation || (timeout && !asleep)) begin
         rst_out_q   <= 1'b1;
         pulse_cnt_q <= 8'(WWD_RST_PULSE_CYC - 1);
      end else if (pulse_cnt_q != 8'h00) begin
         pulse_cnt_q <= pulse_cnt_q - 8'h01;
      end else begin
         rst_out_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= timeout && asleep;
      end
   end

   // set by power-on reset or software, cleared by violation; clear wins
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wv_flag_q <= 1'b1;
      end else if (violation) begin
         wv_flag_q <= 1'b0;
      end else if (flag_set_sw) begin
         wv_flag_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         active_q <= 1'b0;
      end else begin
         active_q <= run;
      end
   end

   // ---------------------------------------------------------------
   // read data, one cycle after the read strobe
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else if (bus.rd) begin
         case (bus.addr)
            WWD_ADDR_PERIOD_ENABLE: rdata_q <= {2'h0, prescale_select_q, software_enable_bit_q};
            WWD_ADDR_CLOCK_WINDOW:  rdata_q <= {1'b0, clock_select_q, 1'b0, window_select_q};
            WWD_ADDR_COUNT_LOW:     rdata_q <= prescale_count[7:0];
            WWD_ADDR_COUNT_HIGH:    rdata_q <= prescale_count[15:8];
            WWD_ADDR_TIMER_STATUS:  rdata_q <= {window_counter, armed_q, prescale_count[17:16]};
            default:                rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata                 = rdata_q;
   assign watchdog_reset        = rst_out_q;
   assign wake_request          = wake_q;
   assign window_violation_flag = wv_flag_q;
   assign active                = active_q;

endmodule : wwd_top

/* hw/wwd_window_cmp.sv */
// window open decode from counter and window select
`timescale 1ns/1ps
module wwd_window_cmp (
   // inputs
   input  wire logic [4:0] window_counter,
   input  wire logic [2:0] window_select,
   // result
   output logic            window_open
);
   import wwd_pkg::*;

   logic [4:0] threshold;

   // open when counter at or above four times seven minus select
   always_comb begin
      threshold   = {3'(3'h7 - window_select), 2'h0};
      window_open = (window_counter >= threshold);
   end

endmodule : wwd_window_cmp

/* pkg/wwd_pkg.sv */
// package of register map, field layout, reset values and timing for the windowed watchdog
package wwd_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] WWD_ADDR_PERIOD_ENABLE = 12'h18c;
   localparam logic [11:0] WWD_ADDR_CLOCK_WINDOW  = 12'h18d;
   localparam logic [11:0] WWD_ADDR_COUNT_LOW     = 12'h18e;
   localparam logic [11:0] WWD_ADDR_COUNT_HIGH    = 12'h18f;
   localparam logic [11:0] WWD_ADDR_TIMER_STATUS  = 12'h190;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int WWD_PS_LSB     = 1;
   localparam int WWD_SEN_BIT    = 0;
   localparam int WWD_CS_LSB     = 4;
   localparam int WWD_WIN_LSB    = 0;
   localparam int WWD_TMR_LSB    = 3;
   localparam int WWD_ARMED_BIT  = 2;

   // ---------------------------------------------------------------
   // codes and reset values
   // ---------------------------------------------------------------
   localparam logic [4:0] WWD_PS_UNLOCKED   = 5'h1f;
   localparam logic [4:0] WWD_PS_MAX_VALID  = 5'h12;
   localparam logic [4:0] WWD_PS_DEFAULT    = 5'h0b;
   localparam logic [4:0] WWD_PS_MIN        = 5'h00;
   localparam logic [2:0] WWD_CS_UNLOCKED   = 3'h7;
   localparam logic [2:0] WWD_CS_DEFAULT    = 3'h0;
   localparam logic [2:0] WWD_WIN_UNLOCKED  = 3'h7;
   localparam logic [1:0] WWD_MODE_OFF      = 2'h0;
   localparam logic [1:0] WWD_MODE_SOFT     = 2'h1;
   localparam logic [1:0] WWD_MODE_AWAKE    = 2'h2;
   localparam logic [1:0] WWD_MODE_ON       = 2'h3;
   localparam int         WWD_PS_BASE_SHIFT = 5;
   localparam int         WWD_CNT_W         = 28;
   localparam int         WWD_PSC_W         = 18;
   localparam int         WWD_SYNC_STAGES   = 2;

   // ---------------------------------------------------------------
   // timing: violation reset pulse width
   // ---------------------------------------------------------------
   localparam int WWD_CLK_MHZ       = 20;
   localparam int WWD_RST_PULSE_NS  = 200;
   localparam int WWD_RST_PULSE_CYC = (WWD_RST_PULSE_NS * WWD_CLK_MHZ + 999) / 1000;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] operating_mode;
      logic [4:0] prescale_setting;
      logic [2:0] clock_setting;
      logic [2:0] window_setting;
   } wwd_config_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } wwd_bus_req_t;

   typedef struct packed {
      logic low_freq_internal_osc;
      logic medium_freq_internal_osc;
      logic secondary_osc;
      logic external_osc;
   } wwd_osc_t;

   // prescale select to effective select (divide ratio exponent minus 5), reserved codes act as shortest
   function automatic logic [4:0] wwd_eff_ps(input logic [4:0] ps);
      wwd_eff_ps = (ps > WWD_PS_MAX_VALID) ? WWD_PS_MIN : ps;
   endfunction : wwd_eff_ps

endpackage : wwd_pkg

/* testbench/tb_top.sv */
// self-checking testbench for the windowed watchdog registers
`timescale 1ns/1ps
module tb_top;
   import wwd_pkg::*;

   // -----------------------------------------------------------
   // signals and design
   // -----------------------------------------------------------
   logic         clk = 1'b0;
   logic         rstn = 1'b0;
   wwd_config_t  cfg = '{WWD_MODE_SOFT, WWD_PS_UNLOCKED, WWD_CS_UNLOCKED, WWD_WIN_UNLOCKED};
   logic         asleep = 1'b0;
   logic         clear_instruction = 1'b0;
   logic         flag_set_sw = 1'b0;
   wwd_osc_t     osc = '0;
   wwd_bus_req_t bus = '0;
   logic [7:0]   rdata;
   logic         watchdog_reset;
   logic         wake_request;
   logic         window_violation_flag;
   logic         active;
   logic         osc_on = 1'b0;
   logic         got;
   int           n_fail = 0;
   int           comparisons = 0;

   // 20 MHz clock, oscillator unrelated in phase
   always #25 clk = ~clk;
   always #180 if (osc_on) osc.low_freq_internal_osc = ~osc.low_freq_internal_osc;

   wwd_top u_wwd_top (.clk(clk), .rstn(rstn), .cfg(cfg), .asleep(asleep), .clear_instruction(clear_instruction),
      .flag_set_sw(flag_set_sw), .osc(osc), .bus(bus), .rdata(rdata), .watchdog_reset(watchdog_reset),
      .wake_request(wake_request), .window_violation_flag(window_violation_flag), .active(active));

   // -----------------------------------------------------------
   // tasks
   // -----------------------------------------------------------
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic results;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) bus <= '0;
   endtask : wr

   // read, then look at the data in the following cycle
   task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input string nm);
      @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) bus <= '0;
      #1 check(nm, rdata, exp);
   endtask : rdc

   task automatic pulse_clear;
      @(posedge clk) clear_instruction <= 1'b1;
      @(posedge clk) clear_instruction <= 1'b0;
   endtask : pulse_clear

   // bounded wait for reset (wake=0) or wake request (wake=1)
   task automatic wait_out(input bit wake, input int lim);
      got = 1'b0;
      for (int i = 0; i < lim && !got; i++) begin
         @(posedge clk) #1 got = wake ? wake_request : watchdog_reset;
      end
   endtask : wait_out

   task automatic restart(input wwd_config_t c);
      @(posedge clk) rstn <= 1'b0;
      cfg <= c;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : restart

   // -----------------------------------------------------------
   // tests
   // -----------------------------------------------------------
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      results();
   end

   initial begin
      // reset values with every setting unlocked
      restart(cfg);
      rdc(WWD_ADDR_TIMER_STATUS, 8'h00, "status");
      rdc(WWD_ADDR_COUNT_LOW, 8'h00, "count low");
      rdc(WWD_ADDR_PERIOD_ENABLE, {2'b00, WWD_PS_DEFAULT, 1'b0}, "period reset");
      rdc(WWD_ADDR_CLOCK_WINDOW, {1'b0, WWD_CS_DEFAULT, 1'b0, WWD_WIN_UNLOCKED}, "window reset");
      rdc(12'h191, 8'h00, "unmapped");
      wr(WWD_ADDR_COUNT_LOW, 8'hff);
      rdc(WWD_ADDR_COUNT_LOW, 8'h00, "count low ro");
      wr(WWD_ADDR_CLOCK_WINDOW, 8'h70);
      rdc(WWD_ADDR_CLOCK_WINDOW, 8'h70, "window write");
      wr(WWD_ADDR_CLOCK_WINDOW, 8'h07);
      wr(WWD_ADDR_PERIOD_ENABLE, 8'h27);
      rdc(WWD_ADDR_PERIOD_ENABLE, 8'h27, "reserved select");
      check("active", active, 1'b1);
      // reserved select runs out after 32 oscillator ticks
      osc_on = 1'b1;
      wait_out(1'b0, 180);
      check("early timeout", got, 1'b0);
      wait_out(1'b0, 100);
      check("timeout", got, 1'b1);
      check("flag kept", window_violation_flag, 1'b1);
      osc_on = 1'b0;
      // clear without arming, then flag set back
      restart(cfg);
      wr(WWD_ADDR_PERIOD_ENABLE, 8'h01);
      pulse_clear();
      wait_out(1'b0, 8);
      check("unarmed clear", got, 1'b1);
      check("flag cleared", window_violation_flag, 1'b0);
      @(posedge clk) flag_set_sw <= 1'b1;
      @(posedge clk) flag_set_sw <= 1'b0;
      repeat (6) @(posedge clk);
      check("flag set", window_violation_flag, 1'b1);
      // armed clear in an open window is accepted
      wr(WWD_ADDR_PERIOD_ENABLE, 8'h01);
      rdc(WWD_ADDR_PERIOD_ENABLE, 8'h01, "arm read");
      rdc(WWD_ADDR_TIMER_STATUS, 8'h04, "armed");
      pulse_clear();
      wait_out(1'b0, 8);
      check("armed clear", got, 1'b0);
      // smallest window is closed at count zero
      wr(WWD_ADDR_CLOCK_WINDOW, 8'h00);
      rdc(WWD_ADDR_PERIOD_ENABLE, 8'h01, "arm again");
      pulse_clear();
      wait_out(1'b0, 8);
      check("closed window", got, 1'b1);
      // time-out while asleep wakes instead of resetting
      @(posedge clk) asleep <= 1'b1;
      osc_on = 1'b1;
      wait_out(1'b1, 320);
      check("wake", got, 1'b1);
      check("no reset asleep", watchdog_reset, 1'b0);
      osc_on = 1'b0;
      @(posedge clk) asleep <= 1'b0;
      // locked settings ignore writes
      restart('{WWD_MODE_OFF, 5'h02, 3'h1, 3'h3});
      rdc(WWD_ADDR_PERIOD_ENABLE, 8'h04, "locked select");
      rdc(WWD_ADDR_CLOCK_WINDOW, 8'h13, "locked window");
      wr(WWD_ADDR_PERIOD_ENABLE, 8'hff);
      wr(WWD_ADDR_CLOCK_WINDOW, 8'hff);
      rdc(WWD_ADDR_PERIOD_ENABLE, 8'h05, "select ro");
      rdc(WWD_ADDR_CLOCK_WINDOW, 8'h13, "clock window ro");
      check("off", active, 1'b0);
      results();
   end
endmodule : tb_top

/* testbench/wwd_checker.sv */
// assertion checker for the windowed watchdog ports
`timescale 1ns/1ps
module wwd_checker
   import wwd_pkg::*;
(
   // clock and reset
   input wire logic                  clk,
   input wire logic                  rstn,
   // inputs
   input wire wwd_pkg::wwd_config_t  cfg,
   input wire logic                  asleep,
   input wire logic                  clear_instruction,
   input wire logic                  flag_set_sw,
   input wire wwd_pkg::wwd_osc_t     osc,
   input wire wwd_pkg::wwd_bus_req_t bus,
   // outputs
   input wire logic [7:0]            rdata,
   input wire logic                  watchdog_reset,
   input wire logic                  wake_request,
   input wire logic                  window_violation_flag,
   input wire logic                  active
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   logic unarmed_q;
   // set by reset or a clear, dropped by an arming read
   always_ff @(posedge clk) begin
      if (!rstn || clear_instruction) unarmed_q <= 1'b1;
      else if (bus.rd && bus.addr == WWD_ADDR_PERIOD_ENABLE) unarmed_q <= 1'b0;
   end

   sequence arm_read;
      bus.rd && bus.addr == WWD_ADDR_PERIOD_ENABLE && !clear_instruction;
   endsequence
   sequence status_read;
      bus.rd && bus.addr == WWD_ADDR_TIMER_STATUS && !clear_instruction;
   endsequence

   chk_reset_pulse: assert property ($rose(watchdog_reset) |-> watchdog_reset [*4] ##1 !watchdog_reset)
      else $error("reset pulse width wrong");
   chk_flag_fall: assert property ($fell(window_violation_flag) |-> ##[0:1] watchdog_reset)
      else $error("flag cleared without reset");
   chk_flag_rise: assert property ($rose(window_violation_flag) |-> $past(flag_set_sw))
      else $error("flag set without request");
   chk_unarmed_clear: assert property (active && clear_instruction && unarmed_q && !bus.rd |=> watchdog_reset)
      else $error("unarmed clear not caught");
   chk_armed_status: assert property (arm_read ##2 status_read |=> rdata[WWD_ARMED_BIT])
      else $error("armed bit not shown");
   chk_soft_enable: assert property (bus.wr && bus.addr == WWD_ADDR_PERIOD_ENABLE
      && cfg.operating_mode == WWD_MODE_SOFT |-> ##2 active == $past(bus.wdata[WWD_SEN_BIT], 2))
      else $error("enable bit not followed");
   chk_mode_off: assert property ((cfg.operating_mode == WWD_MODE_OFF) [*3] |-> !active)
      else $error("active while off");
   chk_wake_sleep: assert property (wake_request |-> (asleep || $past(asleep)) && !watchdog_reset ##1 !wake_request)
      else $error("wake pulse wrong");
   chk_timeout_flag: assert property ($rose(watchdog_reset) && !$past(clear_instruction)
      |-> window_violation_flag == $past(window_violation_flag))
      else $error("timeout touched flag");
endmodule : wwd_checker

bind wwd_top wwd_checker u_wwd_checker (.clk(clk), .rstn(rstn), .cfg(cfg), .asleep(asleep),
   .clear_instruction(clear_instruction), .flag_set_sw(flag_set_sw), .osc(osc), .bus(bus), .rdata(rdata),
   .watchdog_reset(watchdog_reset), .wake_request(wake_request), .window_violation_flag(window_violation_flag),
   .active(active));
